// ### hdl/rcs_pkg.sv
package rcs_pkg;

    // -------------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // -------------------------------------------------------------------
    localparam logic [7:0]  RCS_ADDR_CAUSE   = 8'h00;
    localparam logic [7:0]  RCS_ADDR_STACK   = 8'h04;
    localparam logic [7:0]  RCS_ADDR_PC      = 8'h08;
    localparam logic [7:0]  RCS_ADDR_TOP     = 8'h0c;
    localparam logic [7:0]  RCS_ADDR_LAST    = 8'h10;
    localparam logic [7:0]  RCS_ADDR_SCRATCH = 8'h14;

    // -------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------
    localparam int RCS_BIT_SBOR  = 6;
    localparam int RCS_BIT_RI    = 4;
    localparam int RCS_BIT_TO    = 3;
    localparam int RCS_BIT_PD    = 2;
    localparam int RCS_BIT_POR   = 1;
    localparam int RCS_BIT_BOR   = 0;
    localparam int RCS_BIT_OVER  = 7;
    localparam int RCS_BIT_UNDER = 6;

    // -------------------------------------------------------------------
    // Vectors, steps and codes
    // -------------------------------------------------------------------
    localparam logic [20:0] RCS_RESET_VEC = 21'h000000;
    localparam logic [20:0] RCS_HI_VEC    = 21'h000008;
    localparam logic [20:0] RCS_LO_VEC    = 21'h000018;
    localparam logic [20:0] RCS_PC_STEP   = 21'h000002;
    localparam logic [1:0]  RCS_BOR_OFF   = 2'h0;
    localparam logic [1:0]  RCS_BOR_SOFT  = 2'h1;
    localparam logic [1:0]  RCS_BOR_NOSLP = 2'h2;
    localparam logic [1:0]  RCS_HTRANS_NS = 2'h2;

    typedef enum logic [1:0] {
        RCS_MODE_FULL  = 2'h0,
        RCS_MODE_RUN   = 2'h1,
        RCS_MODE_IDLE  = 2'h2,
        RCS_MODE_SLEEP = 2'h3
    } rcs_mode_t;

    typedef enum logic [1:0] {
        RCS_CLS_NONE  = 2'h0,
        RCS_CLS_POWER = 2'h1,
        RCS_CLS_OTHER = 2'h2,
        RCS_CLS_WAKE  = 2'h3
    } rcs_class_t;

    typedef enum logic [11:0] {
        RCS_C_NONE      = 12'h000,
        RCS_C_BOR       = 12'h001,
        RCS_C_INSTR     = 12'h002,
        RCS_C_PIN_RUN   = 12'h004,
        RCS_C_PIN_SLEEP = 12'h008,
        RCS_C_PIN_FULL  = 12'h010,
        RCS_C_WDT_RST   = 12'h020,
        RCS_C_WDT_WAKE  = 12'h040,
        RCS_C_STK_OVER  = 12'h080,
        RCS_C_STK_UNDER = 12'h100,
        RCS_C_STK_ERR   = 12'h200,
        RCS_C_IRQ_WAKE  = 12'h400,
        RCS_C_IRQ_VEC   = 12'h800
    } rcs_cause_t;

    typedef struct packed {
        logic brownout;
        logic reset_instr;
        logic watchdog;
        logic stack_over;
        logic stack_under;
        logic wake_irq;
    } rcs_evt_t;

    typedef struct packed {
        logic soft_brownout_enable;
        logic reset_instr_flag;
        logic watchdog_expiry_flag;
        logic power_down_flag;
        logic power_on_flag;
        logic brownout_flag;
    } rcs_flags_t;

endpackage

// ### hdl/rcs_reset_cause.sv
`timescale 1ns/1ps
// Contract
// - Resettable registers take values chosen by the class of reset.
// - Registers without reset state power up unknown, keep value across resets.
// - Watchdog wake-up leaves most registers untouched.
// - Power-on loads PC 0, sets instr/watchdog/power-down and soft brown-out enable, clears others.
// - Reset instruction clears its flag; brown-out sets three, clears brown-out.
// - Pin reset in run mode vectors to 0 and sets watchdog flag.
// - Pin reset in idle/sleep sets watchdog flag, clears power-down flag.
// - Pin reset at full power vectors to 0, flags unchanged.
// - Watchdog time-out while running resets to 0, clears watchdog flag.
// - Watchdog in idle/sleep resumes at PC+2, clears watchdog and power-down.
// - Interrupt wake clears power-down flag; without a global enable it resumes at PC+2.
// - Interrupt wake with a global enable loads high or low vector.
// - Interrupt wake with enable pushes PC to stack top, bumps index.
// - Overflow with fault reset enabled resets to 0, sets overflow flag.
// - Underflow with fault reset enabled resets to 0, sets underrun flag.
// - Underflow with fault reset disabled only sets flag, PC reads 0.
// - Soft brown-out enable: 1 at power-on, kept only in soft mode.
// - Three value sets: power/brown-out, other resets, wake-ups.
// - Unimplemented bits always read as zero.
// - Power-on flag cleared only by power-on, never set by hardware.
// - Brown-out flag goes 0 on both brown-out and power-on.
module rcs_reset_cause
    import rcs_pkg::*;
#(
    parameter int PC_W  = 21,
    parameter int IDX_W = 5
)(
    input  wire logic             mclk_i,
    input  wire logic             rst_n_i,
    // AHB-Lite slave
    input  wire logic             hsel_i,
    input  wire logic [31:0]      haddr_i,
    input  wire logic [1:0]       htrans_i,
    input  wire logic             hwrite_i,
    input  wire logic [2:0]       hsize_i,
    input  wire logic [31:0]      hwdata_i,
    input  wire logic             hready_i,
    output logic      [31:0]      hrdata_o,
    output logic                  hreadyout_o,
    output logic                  hresp_o,
    // Reset and wake sources
    input  wire logic             ext_reset_pin_n_i,
    input  rcs_evt_t              evt_i,
    input  rcs_mode_t             power_mode_i,
    input  wire logic [1:0]       brownout_config_field_i,
    input  wire logic             stack_fault_reset_enable_i,
    input  wire logic             high_priority_global_enable_i,
    input  wire logic             low_priority_global_enable_i,
    input  wire logic             irq_high_i,
    input  wire logic [PC_W-1:0]  pc_i,
    // To core and peripherals
    output logic                  pc_load_o,
    output logic      [PC_W-1:0]  pc_value_o,
    output logic                  core_reset_o,
    output rcs_class_t            reset_class_o
);

    // -------------------------------------------------------------------
    // Elaboration checks
    // -------------------------------------------------------------------
    if (PC_W != 21) begin : g_pc_chk
        $error("rcs_reset_cause: PC_W must be 21");
    end
    if (IDX_W < 1 || IDX_W > 6) begin : g_idx_chk
        $error("rcs_reset_cause: IDX_W must be 1..6");
    end

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    rcs_flags_t        flags;
    rcs_flags_t        next_flags;
    logic              stack_over;
    logic              stack_under;
    logic [IDX_W-1:0]  stack_idx;
    logic [PC_W-1:0]   stack_top;
    logic [31:0]       scratch;
    rcs_cause_t        last_cause;
    rcs_cause_t        cause;
    logic [2:0]        pin_sync;
    logic              pin_fell;
    logic              wr_pend;
    logic [7:0]        wr_addr;
    logic              rd_req;
    logic [31:0]       rd_word;
    logic              soft_mode;
    logic              bor_on;

    // Brown-out detector only counts when its configuration arms it
    function automatic logic bor_armed(input logic [1:0] cfg, input logic sbor,
                                       input rcs_mode_t mode);
        unique case (cfg)
            RCS_BOR_OFF:   bor_armed = 1'b0;
            RCS_BOR_SOFT:  bor_armed = sbor;
            RCS_BOR_NOSLP: bor_armed = (mode != RCS_MODE_SLEEP);
            default:       bor_armed = 1'b1;
        endcase
    endfunction

    function automatic logic low_power(input rcs_mode_t mode);
        low_power = (mode == RCS_MODE_IDLE) || (mode == RCS_MODE_SLEEP);
    endfunction

    // -------------------------------------------------------------------
    // Pin synchroniser
    // -------------------------------------------------------------------
    // Stage 0 is read only by stage 1; the edge is taken on later stages
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            pin_sync <= 3'h7;
        else
            pin_sync <= {pin_sync[1:0], ext_reset_pin_n_i};
    end

    assign pin_fell  = pin_sync[2] & ~pin_sync[1];
    assign soft_mode = (brownout_config_field_i == RCS_BOR_SOFT);
    assign bor_on    = bor_armed(brownout_config_field_i,
                                 flags.soft_brownout_enable, power_mode_i);

    // -------------------------------------------------------------------
    // Cause decode
    // -------------------------------------------------------------------
    // Fixed priority: brown-out, pin, watchdog, stack, instruction, wake
    always_comb
    begin
        cause = RCS_C_NONE;
        if (evt_i.brownout && bor_on)
            cause = RCS_C_BOR;
        else if (pin_fell)
        begin
            unique case (power_mode_i)
                RCS_MODE_FULL:  cause = RCS_C_PIN_FULL;
                RCS_MODE_RUN:   cause = RCS_C_PIN_RUN;
                default:        cause = RCS_C_PIN_SLEEP;
            endcase
        end
        else if (evt_i.watchdog)
            cause = low_power(power_mode_i) ? RCS_C_WDT_WAKE : RCS_C_WDT_RST;
        else if (evt_i.stack_over && stack_fault_reset_enable_i)
            cause = RCS_C_STK_OVER;
        else if (evt_i.stack_under)
            cause = stack_fault_reset_enable_i ? RCS_C_STK_UNDER : RCS_C_STK_ERR;
        else if (evt_i.reset_instr)
            cause = RCS_C_INSTR;
        else if (evt_i.wake_irq && low_power(power_mode_i))
            cause = (high_priority_global_enable_i || low_priority_global_enable_i)
                    ? RCS_C_IRQ_VEC : RCS_C_IRQ_WAKE;
    end

    // -------------------------------------------------------------------
    // Reset-cause flags
    // -------------------------------------------------------------------
    // Software write first, event applied after it so a set is never lost
    always_comb
    begin
        next_flags = flags;
        if (wr_pend && wr_addr == RCS_ADDR_CAUSE)
        begin
            next_flags.soft_brownout_enable = hwdata_i[RCS_BIT_SBOR];
            next_flags.reset_instr_flag     = hwdata_i[RCS_BIT_RI];
            next_flags.watchdog_expiry_flag = hwdata_i[RCS_BIT_TO];
            next_flags.power_down_flag      = hwdata_i[RCS_BIT_PD];
            next_flags.power_on_flag        = hwdata_i[RCS_BIT_POR];
            next_flags.brownout_flag        = hwdata_i[RCS_BIT_BOR];
        end
        unique case (cause)
            RCS_C_BOR:
            begin
                next_flags.reset_instr_flag     = 1'b1;
                next_flags.watchdog_expiry_flag = 1'b1;
                next_flags.power_down_flag      = 1'b1;
                next_flags.brownout_flag        = 1'b0;
            end
            RCS_C_INSTR:     next_flags.reset_instr_flag = 1'b0;
            RCS_C_PIN_RUN:   next_flags.watchdog_expiry_flag = 1'b1;
            RCS_C_PIN_SLEEP:
            begin
                next_flags.watchdog_expiry_flag = 1'b1;
                next_flags.power_down_flag      = 1'b0;
            end
            RCS_C_WDT_RST:   next_flags.watchdog_expiry_flag = 1'b0;
            RCS_C_WDT_WAKE:
            begin
                next_flags.watchdog_expiry_flag = 1'b0;
                next_flags.power_down_flag      = 1'b0;
            end
            RCS_C_IRQ_WAKE,
            RCS_C_IRQ_VEC:   next_flags.power_down_flag = 1'b0;
            default:         next_flags.power_down_flag = next_flags.power_down_flag;
        endcase
        // Enable survives an event only in soft mode
        if (cause != RCS_C_NONE && !soft_mode)
            next_flags.soft_brownout_enable = 1'b0;
    end

    // Power-on values; synchronous reset stands in for power-on
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            flags.soft_brownout_enable <= 1'b1;
            flags.reset_instr_flag     <= 1'b1;
            flags.watchdog_expiry_flag <= 1'b1;
            flags.power_down_flag      <= 1'b1;
            flags.power_on_flag        <= 1'b0;
            flags.brownout_flag        <= 1'b0;
        end
        else
            flags <= next_flags;
    end

    // -------------------------------------------------------------------
    // Hardware stack state
    // -------------------------------------------------------------------
    // Index keeps its value over non-power resets; top clears on them
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            stack_over  <= 1'b0;
            stack_under <= 1'b0;
            stack_idx   <= '0;
            stack_top   <= RCS_RESET_VEC;
        end
        else
        begin
            if (wr_pend && wr_addr == RCS_ADDR_STACK)
            begin
                stack_over  <= hwdata_i[RCS_BIT_OVER];
                stack_under <= hwdata_i[RCS_BIT_UNDER];
            end
            if (cause == RCS_C_STK_OVER)
                stack_over <= 1'b1;
            if (cause == RCS_C_STK_UNDER || cause == RCS_C_STK_ERR)
                stack_under <= 1'b1;
            if (cause == RCS_C_IRQ_VEC)
            begin
                stack_top <= pc_i;
                stack_idx <= stack_idx + 1'b1;
            end
            else if (cause != RCS_C_NONE && cause != RCS_C_IRQ_WAKE
                     && cause != RCS_C_WDT_WAKE && cause != RCS_C_STK_ERR)
                stack_top <= RCS_RESET_VEC;
        end
    end

    // -------------------------------------------------------------------
    // Program counter and class outputs
    // -------------------------------------------------------------------
    // Class and value hold until the next event; load is a pulse
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            pc_load_o     <= 1'b1;
            pc_value_o    <= RCS_RESET_VEC;
            core_reset_o  <= 1'b1;
            reset_class_o <= RCS_CLS_POWER;
            last_cause    <= RCS_C_NONE;
        end
        else
        begin
            pc_load_o    <= (cause != RCS_C_NONE);
            core_reset_o <= 1'b0;
            if (cause != RCS_C_NONE)
                last_cause <= cause;
            unique case (cause)
                RCS_C_BOR:
                begin
                    pc_value_o    <= RCS_RESET_VEC;
                    core_reset_o  <= 1'b1;
                    reset_class_o <= RCS_CLS_POWER;
                end
                RCS_C_WDT_WAKE,
                RCS_C_IRQ_WAKE:
                begin
                    pc_value_o    <= pc_i + RCS_PC_STEP;
                    reset_class_o <= RCS_CLS_WAKE;
                end
                RCS_C_IRQ_VEC:
                begin
                    pc_value_o    <= irq_high_i ? RCS_HI_VEC : RCS_LO_VEC;
                    reset_class_o <= RCS_CLS_WAKE;
                end
                RCS_C_STK_ERR:
                    pc_value_o    <= RCS_RESET_VEC;
                RCS_C_NONE:
                    pc_value_o    <= pc_value_o;
                default:
                begin
                    pc_value_o    <= RCS_RESET_VEC;
                    core_reset_o  <= 1'b1;
                    reset_class_o <= RCS_CLS_OTHER;
                end
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Scratch word with no reset state
    // -------------------------------------------------------------------
    // Left out of reset on purpose: unknown at power-up, kept otherwise
    always_ff @(posedge mclk_i)
    begin
        if (wr_pend && wr_addr == RCS_ADDR_SCRATCH)
            scratch <= hwdata_i;
    end

    // -------------------------------------------------------------------
    // AHB-Lite slave
    // -------------------------------------------------------------------
    // Zero-wait slave: read data is latched at the address phase edge
    assign rd_req = hsel_i && hready_i && htrans_i[1] && !hwrite_i;

    always_comb
    begin
        rd_word = 32'h0000_0000;
        unique case (haddr_i[7:0])
            RCS_ADDR_CAUSE:
            begin
                rd_word[RCS_BIT_SBOR] = flags.soft_brownout_enable & soft_mode;
                rd_word[RCS_BIT_RI]   = flags.reset_instr_flag;
                rd_word[RCS_BIT_TO]   = flags.watchdog_expiry_flag;
                rd_word[RCS_BIT_PD]   = flags.power_down_flag;
                rd_word[RCS_BIT_POR]  = flags.power_on_flag;
                rd_word[RCS_BIT_BOR]  = flags.brownout_flag;
            end
            RCS_ADDR_STACK:
            begin
                rd_word[RCS_BIT_OVER]  = stack_over;
                rd_word[RCS_BIT_UNDER] = stack_under;
                rd_word[IDX_W-1:0]     = stack_idx;
            end
            RCS_ADDR_PC:      rd_word[PC_W-1:0] = pc_value_o;
            RCS_ADDR_TOP:     rd_word[PC_W-1:0] = stack_top;
            RCS_ADDR_LAST:    rd_word[11:0]     = last_cause;
            RCS_ADDR_SCRATCH: rd_word           = scratch;
            default:          rd_word           = 32'h0000_0000;
        endcase
        if (haddr_i[31:8] != 24'h000000)
            rd_word = 32'h0000_0000;
    end

    // Write address is held for the data phase that follows
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end
        else
        begin
            wr_pend <= hsel_i && hready_i && htrans_i == RCS_HTRANS_NS && hwrite_i
                       && haddr_i[31:8] == 24'h000000 && hsize_i == 3'h2;
            wr_addr <= haddr_i[7:0];
        end
    end

    // Always OKAY and never stalls
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            hrdata_o    <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
        else
        begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
            if (rd_req)
                hrdata_o <= rd_word;
        end
    end

endmodule

// ### test/rcs_reset_cause_sva.sv
`timescale 1ns/1ps
module rcs_reset_cause_sva
    import rcs_pkg::*;
#(
    parameter int PC_W = 21
)(
    input wire logic            mclk_i,
    input wire logic            rst_n_i,
    input wire logic            hreadyout_o,
    input wire logic            hresp_o,
    input wire logic            ext_reset_pin_n_i,
    input rcs_evt_t             evt_i,
    input rcs_mode_t            power_mode_i,
    input wire logic            stack_fault_reset_enable_i,
    input wire logic            high_priority_global_enable_i,
    input wire logic            low_priority_global_enable_i,
    input wire logic            irq_high_i,
    input wire logic [PC_W-1:0] pc_i,
    input wire logic            pc_load_o,
    input wire logic [PC_W-1:0] pc_value_o,
    input wire logic            core_reset_o,
    input rcs_class_t           reset_class_o
);
    // ----------------
    // Helper logic
    // ----------------
    logic [3:0] pin_hist;
    logic       quiet;
    logic       gie;
    logic       live;

    // Pin history; a recent pin edge may outrank any event except brown-out
    always_ff @(posedge mclk_i)
        pin_hist <= {pin_hist[2:0], ext_reset_pin_n_i};

    // Reset seen one edge late; the release edge still shows reset outputs
    always_ff @(posedge mclk_i)
        live <= rst_n_i;

    // No pin activity in flight, and any global enable
    assign quiet = &{pin_hist, ext_reset_pin_n_i};
    assign gie   = high_priority_global_enable_i | low_priority_global_enable_i;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i || !live);

    // ----------------
    // Properties
    // ----------------
    bus_ok_a: assert property (hreadyout_o && !hresp_o)
        else $error("bus stalled or error response");
    wdt_wake_a: assert property (quiet && evt_i == 6'h08 && power_mode_i[1] |=>
        pc_load_o && !core_reset_o && pc_value_o == $past(pc_i) + RCS_PC_STEP)
        else $error("watchdog wake did not resume at pc plus two");
    wdt_run_a: assert property (quiet && evt_i == 6'h08 && !power_mode_i[1] |=>
        core_reset_o && pc_value_o == '0 && reset_class_o == RCS_CLS_OTHER)
        else $error("watchdog while running did not reset");
    stk_over_a: assert property (quiet && evt_i == 6'h04 && stack_fault_reset_enable_i |=>
        core_reset_o && reset_class_o == RCS_CLS_OTHER)
        else $error("overflow did not reset core");
    stk_soft_a: assert property (quiet && evt_i == 6'h02 && !stack_fault_reset_enable_i |=>
        pc_load_o && !core_reset_o && pc_value_o == '0)
        else $error("soft underflow handled wrongly");
    irq_vec_a: assert property (quiet && evt_i == 6'h01 && power_mode_i[1] && gie |=>
        pc_value_o == ($past(irq_high_i) ? RCS_HI_VEC : RCS_LO_VEC))
        else $error("interrupt wake took wrong vector");
    irq_plain_a: assert property (quiet && evt_i == 6'h01 && power_mode_i[1] && !gie |=>
        pc_value_o == $past(pc_i) + RCS_PC_STEP && reset_class_o == RCS_CLS_WAKE)
        else $error("interrupt wake did not resume at pc plus two");
    reset_vec_a: assert property (core_reset_o |-> pc_load_o && pc_value_o == '0)
        else $error("core reset without zero vector");
    idle_quiet_a: assert property (quiet && evt_i == '0 |=>
        !pc_load_o && $stable(reset_class_o))
        else $error("output moved without a cause");
endmodule

bind rcs_reset_cause rcs_reset_cause_sva #(.PC_W(PC_W)) rcs_reset_cause_sva_i (
    .mclk_i, .rst_n_i, .hreadyout_o, .hresp_o, .ext_reset_pin_n_i, .evt_i,
    .power_mode_i, .stack_fault_reset_enable_i, .high_priority_global_enable_i,
    .low_priority_global_enable_i, .irq_high_i, .pc_i, .pc_load_o, .pc_value_o,
    .core_reset_o, .reset_class_o);

// ### test/rcs_reset_cause_test.sv
`timescale 1ns/1ps
module rcs_reset_cause_test import rcs_pkg::*;;
    logic        mclk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        hsel_i = 1'b1;
    logic [31:0] haddr_i = '0;
    logic [1:0]  htrans_i = '0;
    logic        hwrite_i = 1'b0;
    logic [2:0]  hsize_i = 3'h2;
    logic [31:0] hwdata_i = '0;
    logic [31:0] hrdata_o;
    logic        hreadyout_o;
    logic        hresp_o;
    logic        ext_reset_pin_n_i = 1'b1;
    rcs_evt_t    evt_i = '0;
    rcs_mode_t   power_mode_i = RCS_MODE_FULL;
    logic [1:0]  brownout_config_field_i = RCS_BOR_SOFT;
    logic        stack_fault_reset_enable_i = 1'b1;
    logic        high_priority_global_enable_i = 1'b0;
    logic        low_priority_global_enable_i = 1'b0;
    logic        irq_high_i = 1'b0;
    logic [20:0] pc_i = 21'h001234;
    logic        pc_load_o;
    logic [20:0] pc_value_o;
    logic        core_reset_o;
    rcs_class_t  reset_class_o;
    int          err_count = 0;
    int          checks = 0;

    // 100 MHz clock
    always #5 mclk_i = ~mclk_i;

    rcs_reset_cause rcs_reset_cause_i (
        .mclk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
        .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
        .ext_reset_pin_n_i, .evt_i, .power_mode_i, .brownout_config_field_i,
        .stack_fault_reset_enable_i, .high_priority_global_enable_i,
        .low_priority_global_enable_i, .irq_high_i, .pc_i, .pc_load_o,
        .pc_value_o, .core_reset_o, .reset_class_o);

    // ----------------
    // Tasks
    // ----------------
    task results;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bounded wait for hready; a hang ends the run
    task wt;
        int n;
        n = 0;
        do
        begin
            @(posedge mclk_i);
            n++;
        end
        while (hreadyout_o !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            err_count++;
            results();
        end
    endtask

    task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r);
        haddr_i  <= {24'h0, a};
        hwrite_i <= w;
        htrans_i <= RCS_HTRANS_NS;
        wt();
        htrans_i <= 2'h0;
        hwdata_i <= d;
        wt();
        r = hrdata_o;
    endtask

    task chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        cmp(r, e);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    // One-cycle event pulse, then one settling cycle
    task ev(input logic [5:0] e, input rcs_mode_t m);
        power_mode_i <= m;
        evt_i        <= rcs_evt_t'(e);
        @(posedge mclk_i);
        evt_i <= '0;
        @(posedge mclk_i);
    endtask

    // Pin pulse; the synchroniser needs three edges
    task pin(input rcs_mode_t m);
        power_mode_i      <= m;
        ext_reset_pin_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        ext_reset_pin_n_i <= 1'b1;
        repeat (6) @(posedge mclk_i);
    endtask

    task rst;
        rst_n_i <= 1'b0;
        repeat (8) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
    endtask

    // ----------------
    // Main sequence
    // ----------------
    initial
    begin
        rst();
        chk(RCS_ADDR_CAUSE, 32'h5c);
        chk(RCS_ADDR_STACK, 32'h00);
        chk(RCS_ADDR_PC, 32'h0);
        wr(RCS_ADDR_CAUSE, 32'hff);
        chk(RCS_ADDR_CAUSE, 32'h5f);
        ev(6'h10, RCS_MODE_FULL);
        chk(RCS_ADDR_CAUSE, 32'h4f);
        ev(6'h20, RCS_MODE_FULL);
        chk(RCS_ADDR_CAUSE, 32'h5e);
        cmp(32'(reset_class_o), 32'(RCS_CLS_POWER));
        ev(6'h08, RCS_MODE_FULL);
        chk(RCS_ADDR_CAUSE, 32'h56);
        ev(6'h08, RCS_MODE_SLEEP);
        chk(RCS_ADDR_CAUSE, 32'h52);
        chk(RCS_ADDR_PC, 32'h1236);
        chk(RCS_ADDR_LAST, 32'(RCS_C_WDT_WAKE));
        wr(RCS_ADDR_CAUSE, 32'h57);
        pin(RCS_MODE_RUN);
        chk(RCS_ADDR_CAUSE, 32'h5f);
        wr(RCS_ADDR_CAUSE, 32'h57);
        pin(RCS_MODE_SLEEP);
        chk(RCS_ADDR_CAUSE, 32'h5b);
        wr(RCS_ADDR_CAUSE, 32'h57);
        pin(RCS_MODE_FULL);
        chk(RCS_ADDR_CAUSE, 32'h57);
        wr(RCS_ADDR_CAUSE, 32'h5f);
        ev(6'h01, RCS_MODE_SLEEP);
        chk(RCS_ADDR_CAUSE, 32'h5b);
        cmp(32'(reset_class_o), 32'(RCS_CLS_WAKE));
        // Vectored wakes push the pc and step the index
        high_priority_global_enable_i <= 1'b1;
        irq_high_i                    <= 1'b1;
        ev(6'h01, RCS_MODE_IDLE);
        chk(RCS_ADDR_PC, 32'h08);
        chk(RCS_ADDR_TOP, 32'h1234);
        chk(RCS_ADDR_STACK, 32'h01);
        high_priority_global_enable_i <= 1'b0;
        low_priority_global_enable_i  <= 1'b1;
        irq_high_i                    <= 1'b0;
        ev(6'h01, RCS_MODE_SLEEP);
        chk(RCS_ADDR_PC, 32'h18);
        chk(RCS_ADDR_STACK, 32'h02);
        low_priority_global_enable_i <= 1'b0;
        ev(6'h01, RCS_MODE_FULL);
        chk(RCS_ADDR_PC, 32'h18);
        // Stack faults, enabled then disabled
        ev(6'h04, RCS_MODE_FULL);
        chk(RCS_ADDR_STACK, 32'h82);
        chk(RCS_ADDR_TOP, 32'h0);
        chk(RCS_ADDR_CAUSE, 32'h5b);
        wr(RCS_ADDR_STACK, 32'h0);
        ev(6'h02, RCS_MODE_FULL);
        chk(RCS_ADDR_STACK, 32'h42);
        wr(RCS_ADDR_STACK, 32'h0);
        stack_fault_reset_enable_i <= 1'b0;
        ev(6'h01, RCS_MODE_SLEEP);
        chk(RCS_ADDR_PC, 32'h1236);
        ev(6'h02, RCS_MODE_FULL);
        chk(RCS_ADDR_STACK, 32'h42);
        chk(RCS_ADDR_CAUSE, 32'h5b);
        chk(RCS_ADDR_PC, 32'h0);
        // Brown-out off: enable bit drops, brown-out ignored
        brownout_config_field_i <= RCS_BOR_OFF;
        ev(6'h10, RCS_MODE_FULL);
        chk(RCS_ADDR_CAUSE, 32'h0b);
        ev(6'h20, RCS_MODE_FULL);
        chk(RCS_ADDR_CAUSE, 32'h0b);
        // Brown-out armed everywhere but sleep
        brownout_config_field_i <= RCS_BOR_NOSLP;
        ev(6'h20, RCS_MODE_SLEEP);
        chk(RCS_ADDR_CAUSE, 32'h0b);
        ev(6'h20, RCS_MODE_IDLE);
        chk(RCS_ADDR_CAUSE, 32'h1e);
        wr(RCS_ADDR_SCRATCH, 32'ha5a50f0f);
        rst();
        chk(RCS_ADDR_SCRATCH, 32'ha5a50f0f);
        chk(RCS_ADDR_CAUSE, 32'h1c);
        chk(RCS_ADDR_STACK, 32'h00);
        chk(8'h40, 32'h0);
        results();
    end
endmodule
